//--- sccd_pkg.sv
// How it works
// - CRC code 00 does nothing, so other fields may be written alone.
// - CRC code 01 resets the receive checker; receiver disable or SDLC frame end also do.
// - CRC code 10 resets the transmit generator; channel reset does not; the host model sends it as code 00 while the transmitter is off.
// - CRC code 11 clears underrun latch; underrun with latch clear appends CRC.
// - SDLC with abort-on-underrun sends abort then flag instead of CRC.
// - Latch sets when CRC transmission starts; host may clear it only while the transmitter is enabled.
// - Transmitter disabled: latch stays set, but an ext/status interrupt shows it clear unless ext status is pending without command 010.
// - Command code 000 has no effect.
// - Non-multiplexed: command 001 adds eight to the written pointer.
// - External status stays latched until command 010 unlatches and re-arms it.
// - A second change persisting past the unlatch raises another interrupt.
// - Command 011 sends abort ones, empties transmit buffer, sets underrun status.
// - Command 100 re-arms first-character receive interrupt mode.
// - Command 101 clears transmit pending until a load or CRC completes.
// - Command 110 clears receive error bits and releases held FIFO data.
// - Command 111 clears the highest interrupt-under-service bit.
// - Non-multiplexed: bits two to zero select register 0 to 7 or 8 to 15.
// - Multiplexed: bit two zero; channel B bits 10 shift left, 11 right.
// - Command fields act on write and read back as zeros.
package sccd_pkg;
    localparam logic [1:0] SCCD_CRC_NULL   = 2'h0;
    localparam logic [1:0] SCCD_CRC_RX     = 2'h1;
    localparam logic [1:0] SCCD_CRC_TX     = 2'h2;
    localparam logic [1:0] SCCD_CRC_EOM    = 2'h3;
    localparam logic [2:0] SCCD_CMD_NULL   = 3'h0;
    localparam logic [2:0] SCCD_CMD_HIGH   = 3'h1;
    localparam logic [2:0] SCCD_CMD_EXT    = 3'h2;
    localparam logic [2:0] SCCD_CMD_ABORT  = 3'h3;
    localparam logic [2:0] SCCD_CMD_RXNEXT = 3'h4;
    localparam logic [2:0] SCCD_CMD_TXPEND = 3'h5;
    localparam logic [2:0] SCCD_CMD_ERR    = 3'h6;
    localparam logic [2:0] SCCD_CMD_IUS    = 3'h7;
    localparam logic [1:0] SCCD_SHIFT_LEFT = 2'h2;
    localparam logic [1:0] SCCD_SHIFT_RIGHT = 2'h3;
    localparam int         SCCD_CRC_POS    = 6;
    localparam int         SCCD_CMD_POS    = 3;
    localparam logic [3:0] SCCD_PTR_RST    = 4'h0;
    localparam logic [3:0] SCCD_PTR_HIGH   = 4'h8;
    localparam logic       SCCD_EOM_RST    = 1'b1;
    localparam logic       SCCD_SHIFT_RST  = 1'b0;

    // One-cycle action strobes produced by a command write.
    typedef struct packed {
        logic rx_crc_reset;
        logic tx_crc_reset;
        logic ext_unlatch;
        logic send_abort;
        logic rx_next_arm;
        logic tx_pend_clear;
        logic error_reset;
        logic ius_reset;
    } sccd_pulse_s;
endpackage

//--- sccd_decode.sv
`timescale 1ns/10ps
module sccd_decode (
    input  wire logic               mclk_i,
    input  wire logic               rst_n_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    input  wire logic               sel_cmd_i,
    input  wire logic [7:0]         wdata_i,
    input  wire logic               mux_mode_i,
    input  wire logic               chan_b_i,
    input  wire logic               sdlc_i,
    input  wire logic               abort_on_urun_i,
    input  wire logic               tx_en_i,
    input  wire logic               rx_en_i,
    input  wire logic               crc_start_i,
    input  wire logic               urun_i,
    input  wire logic               ext_pend_i,
    input  wire logic               rx_frame_end_i,
    output logic                    rx_crc_reset_o,
    output logic                    tx_crc_reset_o,
    output logic                    ext_unlatch_o,
    output logic                    send_abort_o,
    output logic                    rx_next_arm_o,
    output logic                    tx_pend_clear_o,
    output logic                    error_reset_o,
    output logic                    ius_reset_o,
    output logic                    eom_latch_o,
    output logic                    append_crc_o,
    output logic                    send_abort_flag_o,
    output logic                    ext_irq_eom_o,
    output logic [3:0]              reg_ptr_o,
    output logic                    shift_right_o,
    output logic [7:0]              rdata_o
);
    logic [3:0]          ptr_q;
    logic                eom_q;
    logic                shift_q;
    sccd_pkg::sccd_pulse_s pulse_q;
    logic                append_q;
    logic                abt_q;
    logic                ext_eom_q;
    logic                rx_en_q;
    logic [1:0]          crc_code;
    logic [2:0]          cmd_code;
    logic                cmd_wr;
    logic                eom_clr;

    // Field extraction is used by several processes.
    function automatic logic [2:0] sccd_cmd(input logic [7:0] d);
        sccd_cmd = d[sccd_pkg::SCCD_CMD_POS +: 3];
    endfunction

    assign cmd_wr   = wr_i & sel_cmd_i;
    assign crc_code = wdata_i[sccd_pkg::SCCD_CRC_POS +: 2];
    assign cmd_code = sccd_cmd(wdata_i);
    // Latch clear only takes hold while the transmitter runs.
    assign eom_clr  = cmd_wr & (crc_code == sccd_pkg::SCCD_CRC_EOM)
                      & tx_en_i;

    // Action strobes last one cycle; code 00 and 000 produce none.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pulse_q <= '0;
            rx_en_q <= 1'b0;
        end else begin
            rx_en_q <= rx_en_i;
            pulse_q.rx_crc_reset <= (cmd_wr
                & (crc_code == sccd_pkg::SCCD_CRC_RX))
                | (rx_en_q & ~rx_en_i)
                | (sdlc_i & rx_frame_end_i);
            pulse_q.tx_crc_reset <= cmd_wr
                & (crc_code == sccd_pkg::SCCD_CRC_TX);
            pulse_q.ext_unlatch <= cmd_wr
                & (cmd_code == sccd_pkg::SCCD_CMD_EXT);
            pulse_q.send_abort <= cmd_wr
                & (cmd_code == sccd_pkg::SCCD_CMD_ABORT);
            pulse_q.rx_next_arm <= cmd_wr
                & (cmd_code == sccd_pkg::SCCD_CMD_RXNEXT);
            pulse_q.tx_pend_clear <= cmd_wr
                & (cmd_code == sccd_pkg::SCCD_CMD_TXPEND);
            pulse_q.error_reset <= cmd_wr
                & (cmd_code == sccd_pkg::SCCD_CMD_ERR);
            pulse_q.ius_reset <= cmd_wr
                & (cmd_code == sccd_pkg::SCCD_CMD_IUS);
        end
    end

    // Underrun/end-of-message latch; hardware set wins over a clear.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            eom_q <= sccd_pkg::SCCD_EOM_RST;
        end else if (crc_start_i | pulse_q.send_abort) begin
            eom_q <= 1'b1;
        end else if (eom_clr) begin
            eom_q <= 1'b0;
        end
    end

    // Underrun reaction chosen from the latch state at the underrun.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            append_q <= 1'b0;
            abt_q    <= 1'b0;
        end else begin
            append_q <= urun_i & ~eom_q
                        & ~(sdlc_i & abort_on_urun_i);
            abt_q    <= urun_i & ~eom_q
                        & sdlc_i & abort_on_urun_i;
        end
    end

    // A clear while disabled reports the latch clear to status logic unless ext status is pending without command 010.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_eom_q <= 1'b0;
        end else begin
            ext_eom_q <= cmd_wr & ~tx_en_i
                & (crc_code == sccd_pkg::SCCD_CRC_EOM)
                & (~ext_pend_i
                   | (cmd_code == sccd_pkg::SCCD_CMD_EXT));
        end
    end

    // Register pointer: set by a command write in non-multiplexed mode,
    // cleared after the next non-command access so the command register follows.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr_q <= sccd_pkg::SCCD_PTR_RST;
        end else if (!mux_mode_i && cmd_wr) begin
            ptr_q <= {1'b0, wdata_i[2:0]}
                | ((cmd_code == sccd_pkg::SCCD_CMD_HIGH)
                   ? sccd_pkg::SCCD_PTR_HIGH
                   : sccd_pkg::SCCD_PTR_RST);
        end else if ((wr_i | rd_i) && !sel_cmd_i) begin
            ptr_q <= sccd_pkg::SCCD_PTR_RST;
        end
    end

    // Shift selection lives on channel B only; bit two must be zero.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_q <= sccd_pkg::SCCD_SHIFT_RST;
        end else if (mux_mode_i && chan_b_i && cmd_wr && !wdata_i[2]) begin
            if (wdata_i[1:0] == sccd_pkg::SCCD_SHIFT_LEFT) begin
                shift_q <= 1'b0;
            end else if (wdata_i[1:0] == sccd_pkg::SCCD_SHIFT_RIGHT) begin
                shift_q <= 1'b1;
            end
        end
    end

    // Command fields are write-only and always read back as zero.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    assign rx_crc_reset_o    = pulse_q.rx_crc_reset;
    assign tx_crc_reset_o    = pulse_q.tx_crc_reset;
    assign ext_unlatch_o     = pulse_q.ext_unlatch;
    assign send_abort_o      = pulse_q.send_abort;
    assign rx_next_arm_o     = pulse_q.rx_next_arm;
    assign tx_pend_clear_o   = pulse_q.tx_pend_clear;
    assign error_reset_o     = pulse_q.error_reset;
    assign ius_reset_o       = pulse_q.ius_reset;
    assign eom_latch_o       = eom_q;
    assign append_crc_o      = append_q;
    assign send_abort_flag_o = abt_q;
    assign ext_irq_eom_o     = ext_eom_q;
    assign reg_ptr_o         = ptr_q;
    assign shift_right_o     = shift_q;

    chk_txcrc_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_wr && crc_code == sccd_pkg::SCCD_CRC_TX |=> tx_crc_reset_o)
        else $error("tx crc reset missing");
    chk_null_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_wr && cmd_code == sccd_pkg::SCCD_CMD_NULL
        |=> !ius_reset_o && !send_abort_o && !error_reset_o)
        else $error("null command acted");
    chk_eom_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        crc_start_i |=> eom_latch_o)
        else $error("latch not set at crc start");
    chk_eom_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        eom_latch_o && !tx_en_i |=> eom_latch_o)
        else $error("latch cleared while disabled");
    chk_eom_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        eom_clr && !crc_start_i && !send_abort_o |=> !eom_latch_o)
        else $error("latch not cleared");
    chk_abort_eom: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_wr && cmd_code == sccd_pkg::SCCD_CMD_ABORT
        |=> send_abort_o ##1 eom_latch_o)
        else $error("abort did not set latch");
    chk_urun_abort: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        urun_i && !eom_latch_o && sdlc_i && abort_on_urun_i
        |=> send_abort_flag_o && !append_crc_o)
        else $error("wrong underrun reaction");
    chk_ptr_high: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !mux_mode_i && cmd_wr && cmd_code == sccd_pkg::SCCD_CMD_HIGH
        |=> reg_ptr_o == {1'b1, $past(wdata_i[2:0])})
        else $error("point high wrong");
    chk_ptr_return: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (wr_i || rd_i) && !sel_cmd_i && !(cmd_wr) |=> reg_ptr_o == 4'h0)
        else $error("pointer not returned");
    chk_read_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        rd_i |=> rdata_o == 8'h00)
        else $error("command read not zero");

    // Receive checker resets: by code, by receiver disable, by SDLC frame end.
    chk_rxcrc_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_wr && crc_code == sccd_pkg::SCCD_CRC_RX |=> rx_crc_reset_o)
        else $error("rx crc reset missing");
    chk_rxcrc_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        rx_en_q && !rx_en_i |=> rx_crc_reset_o)
        else $error("rx crc reset on disable missing");
    chk_rxcrc_sdlc: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        sdlc_i && rx_frame_end_i |=> rx_crc_reset_o)
        else $error("rx crc reset at frame end missing");

    // The null code must leave both CRC circuits alone.
    chk_crc_null: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_wr && crc_code == sccd_pkg::SCCD_CRC_NULL
        && !(rx_en_q && !rx_en_i) && !(sdlc_i && rx_frame_end_i)
        |=> !rx_crc_reset_o && !tx_crc_reset_o)
        else $error("null crc code acted");

    // Only the command resets the generator, never a side effect.
    chk_txcrc_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !(cmd_wr && crc_code == sccd_pkg::SCCD_CRC_TX) |=> !tx_crc_reset_o)
        else $error("tx crc reset without command");

    // Command codes 010 and 100 to 111 each raise their own strobe.
    chk_ext_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_wr && cmd_code == sccd_pkg::SCCD_CMD_EXT |=> ext_unlatch_o)
        else $error("ext unlatch missing");
    chk_ext_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !(cmd_wr && cmd_code == sccd_pkg::SCCD_CMD_EXT) |=> !ext_unlatch_o)
        else $error("ext unlatch without command");
    chk_rxnext_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_wr && cmd_code == sccd_pkg::SCCD_CMD_RXNEXT |=> rx_next_arm_o)
        else $error("rx next arm missing");
    chk_txpend_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_wr && cmd_code == sccd_pkg::SCCD_CMD_TXPEND |=> tx_pend_clear_o)
        else $error("tx pending clear missing");
    chk_err_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_wr && cmd_code == sccd_pkg::SCCD_CMD_ERR |=> error_reset_o)
        else $error("error reset missing");
    chk_ius_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_wr && cmd_code == sccd_pkg::SCCD_CMD_IUS |=> ius_reset_o)
        else $error("ius reset missing");

    // Underrun with the latch clear appends CRC unless abort is chosen.
    chk_urun_append: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        urun_i && !eom_latch_o && !(sdlc_i && abort_on_urun_i)
        |=> append_crc_o && !send_abort_flag_o)
        else $error("crc not appended");
    chk_urun_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        urun_i && eom_latch_o |=> !append_crc_o && !send_abort_flag_o)
        else $error("underrun acted with latch set");

    // The latch only rises through CRC start or a sent abort.
    chk_eom_rise: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(eom_latch_o) |-> $past(crc_start_i) || $past(send_abort_o))
        else $error("latch set without cause");

    // Status report of a refused clear, only while the transmitter is off.
    chk_eirq_free: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_wr && !tx_en_i && crc_code == sccd_pkg::SCCD_CRC_EOM
        && !ext_pend_i |=> ext_irq_eom_o)
        else $error("status report missing");
    chk_eirq_pend: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_wr && !tx_en_i && crc_code == sccd_pkg::SCCD_CRC_EOM
        && ext_pend_i && cmd_code != sccd_pkg::SCCD_CMD_EXT
        |=> !ext_irq_eom_o)
        else $error("status report while pending");
    chk_eirq_tx_on: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        tx_en_i |=> !ext_irq_eom_o)
        else $error("status report while enabled");

    // Pointer loads the low bank, is untouched by command writes in multiplexed mode and
    // holds while the bus is idle.
    chk_ptr_low: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !mux_mode_i && cmd_wr && cmd_code != sccd_pkg::SCCD_CMD_HIGH
        |=> reg_ptr_o == {1'b0, $past(wdata_i[2:0])})
        else $error("pointer low wrong");
    chk_ptr_mux: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        mux_mode_i && cmd_wr |=> $stable(reg_ptr_o))
        else $error("pointer moved in mux mode");
    chk_ptr_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !wr_i && !rd_i |=> $stable(reg_ptr_o))
        else $error("pointer moved while idle");

    // Shift selection follows codes 10 and 11 on channel B only.
    chk_shift_right: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        mux_mode_i && chan_b_i && cmd_wr && !wdata_i[2]
        && wdata_i[1:0] == sccd_pkg::SCCD_SHIFT_RIGHT |=> shift_right_o)
        else $error("shift right not taken");
    chk_shift_left: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        mux_mode_i && chan_b_i && cmd_wr && !wdata_i[2]
        && wdata_i[1:0] == sccd_pkg::SCCD_SHIFT_LEFT |=> !shift_right_o)
        else $error("shift left not taken");
    chk_shift_chan_a: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        !chan_b_i |=> $stable(shift_right_o))
        else $error("shift moved on channel A");
endmodule

//--- sccd_host.sv
`timescale 1ns/10ps
// Host model: a request seen at one edge becomes a one-cycle bus access
// launched just after that same edge, as a processor write strobe would be.
module sccd_host (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       req_wr_i,
    input  wire logic       req_rd_i,
    input  wire logic       req_sel_i,
    input  wire logic [7:0] req_data_i,
    input  wire logic       mux_mode_i,
    input  wire logic       tx_en_i,
    output logic            wr_o,
    output logic            rd_o,
    output logic            sel_cmd_o,
    output logic [7:0]      wdata_o
);
    logic [1:0] crc;
    logic [2:0] low;

    // The generator reset is dropped (sent as code 00) while the transmitter is off.
    assign crc = (!tx_en_i && req_data_i[7:6] == 2'h2) ?
                 2'h0 : req_data_i[7:6];
    // Bit two is written as zero in multiplexed mode.
    assign low = mux_mode_i ? {1'h0, req_data_i[1:0]} : req_data_i[2:0];

    // Between writes the data lines toggle, so stale data never looks fresh.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_o      <= 1'h0;
            rd_o      <= 1'h0;
            sel_cmd_o <= 1'h0;
            wdata_o   <= 8'h00;
        end else begin
            wr_o      <= req_wr_i;
            rd_o      <= req_rd_i;
            sel_cmd_o <= req_sel_i;
            wdata_o   <= req_wr_i ? {crc, req_data_i[5:3], low} : ~wdata_o;
        end
    end
endmodule

//--- test_serial_cmd_register_decode.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    fail_count++; $display("BAD %s exp %0h seen %0h", nm, ex, got); end end
module test_serial_cmd_register_decode;
    logic mclk_i = 1'h0, rst_n_i = 1'h0, rq_wr = 1'h0, rq_rd = 1'h0;
    logic rq_sel = 1'h0, mux = 1'h0, chb = 1'h0, sdlc = 1'h0, abu = 1'h0;
    logic tx_en = 1'h1, rx_en = 1'h1, cst = 1'h0, urun = 1'h0;
    logic pend = 1'h0, fend = 1'h0, wr, rd, sel, end_of_message, app, abf, eirq, shr;
    logic [7:0] rq_d = 8'h00, wd, rdat, b;
    logic [3:0] ptr;
    sccd_pkg::sccd_pulse_s p;
    int fail_count = 0, n_compared = 0, pe;

    sccd_host i_sccd_host (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .req_wr_i(rq_wr), .req_rd_i(rq_rd), .req_sel_i(rq_sel),
        .req_data_i(rq_d), .mux_mode_i(mux), .tx_en_i(tx_en),
        .wr_o(wr), .rd_o(rd), .sel_cmd_o(sel), .wdata_o(wd));
    sccd_decode i_sccd_decode (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .wr_i(wr), .rd_i(rd), .sel_cmd_i(sel), .wdata_i(wd),
        .mux_mode_i(mux), .chan_b_i(chb), .sdlc_i(sdlc),
        .abort_on_urun_i(abu), .tx_en_i(tx_en), .rx_en_i(rx_en),
        .crc_start_i(cst), .urun_i(urun), .ext_pend_i(pend),
        .rx_frame_end_i(fend), .rx_crc_reset_o(p.rx_crc_reset),
        .tx_crc_reset_o(p.tx_crc_reset), .ext_unlatch_o(p.ext_unlatch),
        .send_abort_o(p.send_abort), .rx_next_arm_o(p.rx_next_arm),
        .tx_pend_clear_o(p.tx_pend_clear), .error_reset_o(p.error_reset),
        .ius_reset_o(p.ius_reset), .eom_latch_o(end_of_message), .append_crc_o(app),
        .send_abort_flag_o(abf), .ext_irq_eom_o(eirq), .reg_ptr_o(ptr),
        .shift_right_o(shr), .rdata_o(rdat));

    // Clock at 200 MHz.
    always #2.5 mclk_i = ~mclk_i;

    // Reference model of the strobes, built from integer codes.
    function automatic sccd_pkg::sccd_pulse_s model(int crc, int cmd);
        return {crc == 1, crc == 2, cmd == 2, cmd == 3,
                cmd == 4, cmd == 5, cmd == 6, cmd == 7};
    endfunction

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One access: the host drives it a cycle later, the answer lands a cycle
    // after the taking edge, and the task returns with outputs settled.
    task automatic acc(input logic w, input logic s, input logic [7:0] d);
        @(posedge mclk_i);
        rq_wr <= w;
        rq_rd <= !w;
        rq_sel <= s;
        rq_d <= d;
        @(posedge mclk_i);
        rq_wr <= 1'h0;
        rq_rd <= 1'h0;
        @(posedge mclk_i);
        #1;
    endtask

    // One-cycle event pulse: 0 underrun, 1 CRC start, 2 frame end.
    task automatic kick(input int k);
        @(posedge mclk_i);
        urun <= (k == 0);
        cst <= (k == 1);
        fend <= (k == 2);
        @(posedge mclk_i);
        urun <= 1'h0;
        cst <= 1'h0;
        fend <= 1'h0;
        #1;
    endtask

    // Any hang ends the run as a mismatch.
    initial begin
        repeat (20000) @(posedge mclk_i);
        fail_count++;
        test_done();
    end

    initial begin
        void'($urandom(3));
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'h1;
        #1;
        `CHK("eom", 1'h1, end_of_message)
        `CHK("rdata", 8'h00, rdat)
        // Every CRC code with every command, random pointer bits.
        for (int i = 0; i < 32; i++) begin
            b = {i[4:0], 3'($urandom_range(7))};
            acc(1'h1, 1'h1, b);
            pe = (b[5:3] == 3'h1 ? 8 : 0) + int'(b[2:0]);
            `CHK("pulses", model(i / 8, i % 8), p)
            `CHK("ptr", 4'(pe), ptr)
            @(posedge mclk_i);
            #1;
            `CHK("pulse_end", 8'h00, p)
            acc(1'h0, 1'h0, 8'h00);
            `CHK("ptr_back", 4'h0, ptr)
            `CHK("rdata", 8'h00, rdat)
        end
        $display("test decode done");
        acc(1'h1, 1'h1, 8'hc0);
        `CHK("eom", 1'h0, end_of_message)
        kick(0);
        `CHK("append", 1'h1, app)
        acc(1'h1, 1'h1, 8'hc0);
        sdlc <= 1'h1;
        abu <= 1'h1;
        kick(0);
        `CHK("abort_flag", 1'h1, abf)
        `CHK("append", 1'h0, app)
        kick(2);
        `CHK("rx_crc", 1'h1, p.rx_crc_reset)
        @(posedge mclk_i);
        rx_en <= 1'h0;
        @(posedge mclk_i);
        #1;
        `CHK("rx_crc_off", 1'h1, p.rx_crc_reset)
        rx_en <= 1'h1;
        kick(1);
        `CHK("eom", 1'h1, end_of_message)
        kick(0);
        `CHK("abort_flag", 1'h0, abf | app)
        $display("test underrun done");
        tx_en <= 1'h0;
        for (int j = 0; j < 3; j++) begin
            pend <= (j > 0);
            acc(1'h1, 1'h1, j == 2 ? 8'hd0 : 8'hc0);
            `CHK("ext_irq", 1'(j != 1), eirq)
            `CHK("eom", 1'h1, end_of_message)
        end
        tx_en <= 1'h1;
        acc(1'h1, 1'h1, 8'hc0);
        acc(1'h1, 1'h1, 8'h18);
        `CHK("abort", 1'h1, p.send_abort)
        @(posedge mclk_i);
        #1;
        `CHK("eom", 1'h1, end_of_message)
        $display("test latch done");
        mux <= 1'h1;
        chb <= 1'h1;
        acc(1'h1, 1'h1, 8'h07);
        `CHK("shift", 1'h1, shr)
        acc(1'h1, 1'h1, 8'h02);
        `CHK("shift", 1'h0, shr)
        chb <= 1'h0;
        acc(1'h1, 1'h1, 8'h03);
        `CHK("shift", 1'h0, shr)
        $display("test mux done");
        test_done();
    end
endmodule
